/* File: hw/flash_host_defines.svh */
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// command addresses, upper bits driven low
`define ADDR_555 19'h00555
`define ADDR_2AA 19'h002aa
`define ADDR_ZERO 19'h00000

// command data bytes
`define CMD_UNLOCK1 8'haa
`define CMD_UNLOCK2 8'h55
`define CMD_RESET 8'hf0
`define CMD_ID 8'h90
`define CMD_PROG 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP 8'h10
`define CMD_SECT 8'h30
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30

// step counts per operation
`define STEPS_SINGLE 3'h1
`define STEPS_ID 3'h3
`define STEPS_PROG 3'h4
`define STEPS_ERASE 3'h6
`define STEPS_NONE 3'h0

// timing
`define CLK_NS 40
`define T_ACC_NS 70
`define T_WP_NS 35
`define T_WIN_NS 50000
`define SYNC_CYC 2
`define ACC_CYC ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define WP_CYC ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_CYC (`ACC_CYC + `SYNC_CYC)
`define WIN_CYC (`T_WIN_NS / `CLK_NS)
// margin for accept-to-falling-edge delay of the next load
`define WIN_LOAD (`WIN_CYC - 2)

`endif

/* File: hw/flash_host_pkg.sv */
`default_nettype none

package flash_host_pkg;

	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_RESET = 4'h1,
		OP_ID = 4'h2,
		OP_PROG = 4'h3,
		OP_CHIP_ERASE = 4'h4,
		OP_SECT_ERASE = 4'h5,
		OP_SECT_ADD = 4'h6,
		OP_SUSPEND = 4'h7,
		OP_RESUME = 4'h8
	} op_t;

	typedef struct packed {
		op_t op;
		logic [18:0] addr;
		logic [7:0] data;
	} req_t;

	typedef struct packed {
		logic [18:0] addr;
		logic [7:0] dq_o;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} pins_t;

	typedef enum logic [1:0] {
		BC_IDLE = 2'b00,
		BC_SETUP = 2'b01,
		BC_STROBE = 2'b11,
		BC_HOLD = 2'b10
	} bc_state_t;

	typedef struct packed {
		bc_state_t st;
		logic wr;
		logic [3:0] cnt;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] rdata;
		logic done;
		pins_t pins;
	} bc_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WRITE = 2'b01,
		H_WAIT = 2'b11,
		H_READ = 2'b10
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		req_t req;
		logic [2:0] idx;
		logic [2:0] total;
		logic rd;
		logic [15:0] win;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic rsp_err;
	} host_t;

endpackage

`default_nettype wire

/* File: hw/flash_bus_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.svh"

module flash_bus_cycle (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic wr,
	input wire logic [18:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] dq_i,
	output logic done,
	output logic [7:0] rdata,
	output flash_host_pkg::pins_t pins
);
	import flash_host_pkg::*;

	bc_t s_q;
	bc_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.sync1 = dq_i;
		s_d.sync2 = s_q.sync1;
		unique case (s_q.st)
			BC_IDLE: if (start) begin
				s_d.st = BC_SETUP;
				s_d.wr = wr;
				s_d.pins.addr = addr;
				s_d.pins.dq_o = wdata;
				s_d.pins.ce_n = 1'b0;
			end
			BC_SETUP: begin
				s_d.st = BC_STROBE;
				if (s_q.wr) begin
					// write strobe with oe held high
					s_d.cnt = 4'(`WP_CYC);
					s_d.pins.we_n = 1'b0;
					s_d.pins.dq_oe = 1'b1;
				end else begin
					// read with we held high
					s_d.cnt = 4'(`RD_CYC);
					s_d.pins.oe_n = 1'b0;
				end
			end
			BC_STROBE: if (s_q.cnt == 4'h1) begin
				s_d.st = BC_HOLD;
				s_d.pins.we_n = 1'b1;
				s_d.pins.oe_n = 1'b1;
				if (!s_q.wr) begin
					s_d.rdata = s_q.sync2;
				end
			end else begin
				s_d.cnt = s_q.cnt - 4'h1;
			end
			BC_HOLD: begin
				// data held one cycle past the rising strobe edge
				s_d.st = BC_IDLE;
				s_d.pins.ce_n = 1'b1;
				s_d.pins.dq_oe = 1'b0;
				s_d.done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.pins.ce_n <= 1'b1;
			s_q.pins.oe_n <= 1'b1;
			s_q.pins.we_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;
	assign rdata = s_q.rdata;
	assign pins = s_q.pins;

	write_strobe_a: assert property (@(posedge clk) disable iff (rst)
		!pins.we_n |-> pins.oe_n && !pins.ce_n && pins.dq_oe)
		else $error("write strobe without ce low, oe high or data");

	read_strobe_a: assert property (@(posedge clk) disable iff (rst)
		!pins.oe_n |-> pins.we_n && !pins.ce_n && !pins.dq_oe)
		else $error("read strobe with we low, ce high or data driven");

	write_shape_a: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.we_n) |-> ##1 pins.we_n && pins.dq_oe && !pins.ce_n
			##1 pins.ce_n && !pins.dq_oe && done)
		else $error("write cycle width or data hold wrong");

	read_len_a: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.oe_n) |-> !pins.oe_n[*4] ##1 pins.oe_n ##1 done)
		else $error("read strobe length wrong");

endmodule // flash_bus_cycle
`default_nettype wire

/* File: hw/flash_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.svh"

// How it works
// - One F0H write anywhere resets to read and aborts failed operations.
// - Identifier entry: AAH/555H, 55H/2AAH, 90H/555H, then identifier read.
// - Program: AAH/555H, 55H/2AAH, A0H/555H, then byte to target.
// - Erase: five unlock/setup writes, then 10H/555H chip or 30H/sector.
// - Command writes hold write strobe and chip select low, oe high.
// - Reads drive chip select and oe low, write strobe high.
// - Each extra sector load must start within 50us of the last.
module flash_host (
	input wire logic CLK,
	input wire logic RST,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire flash_host_pkg::req_t REQ,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic RSP_ERR,
	input wire logic [7:0] FLASH_DQ_I,
	output flash_host_pkg::pins_t FLASH
);
	import flash_host_pkg::*;

	host_t s_q;
	host_t s_d;
	logic bc_done;
	logic [7:0] bc_rdata;
	logic bc_start;
	logic bc_wr;
	logic [26:0] cyc;
	logic accept;

	function automatic logic [2:0] n_steps(input op_t op);
		logic [2:0] n;
		unique case (op)
			OP_READ: n = `STEPS_NONE;
			OP_ID: n = `STEPS_ID;
			OP_PROG: n = `STEPS_PROG;
			OP_CHIP_ERASE, OP_SECT_ERASE: n = `STEPS_ERASE;
			default: n = `STEPS_SINGLE;
		endcase
		return n;
	endfunction

	// address and data of write step i
	function automatic logic [26:0] step(input req_t r, input logic [2:0] i);
		logic [26:0] v;
		v = {`ADDR_ZERO, `CMD_RESET};
		unique case (r.op)
			OP_RESET: v = {`ADDR_ZERO, `CMD_RESET};
			OP_SUSPEND: v = {r.addr, `CMD_SUSPEND};
			OP_RESUME: v = {r.addr, `CMD_RESUME};
			OP_SECT_ADD: v = {r.addr, `CMD_SECT};
			default: begin
				unique case (i)
					3'h0: v = {`ADDR_555, `CMD_UNLOCK1};
					3'h1: v = {`ADDR_2AA, `CMD_UNLOCK2};
					3'h2: begin
						if (r.op == OP_ID) begin
							v = {`ADDR_555, `CMD_ID};
						end else if (r.op == OP_PROG) begin
							v = {`ADDR_555, `CMD_PROG};
						end else begin
							v = {`ADDR_555, `CMD_ERASE_SETUP};
						end
					end
					3'h3: begin
						if (r.op == OP_PROG) begin
							v = {r.addr, r.data};
						end else begin
							v = {`ADDR_555, `CMD_UNLOCK1};
						end
					end
					3'h4: v = {`ADDR_2AA, `CMD_UNLOCK2};
					default: begin
						if (r.op == OP_CHIP_ERASE) begin
							v = {`ADDR_555, `CMD_CHIP};
						end else begin
							v = {r.addr, `CMD_SECT};
						end
					end
				endcase
			end
		endcase
		return v;
	endfunction

	assign REQ_READY = (s_q.st == H_IDLE);
	assign accept = REQ_VALID && REQ_READY;
	assign bc_start = (s_q.st == H_WRITE) || (s_q.st == H_READ);
	assign bc_wr = (s_q.st == H_WRITE);
	assign cyc = bc_wr ? step(s_q.req, s_q.idx) : {s_q.req.addr, 8'h00};

	always_comb begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		if (s_q.win != 16'h0) begin
			s_d.win = s_q.win - 16'h1;
		end
		unique case (s_q.st)
			H_IDLE: if (REQ_VALID) begin
				if (REQ.op == OP_SECT_ADD && s_q.win == 16'h0) begin
					// load window closed: refuse
					s_d.rsp_valid = 1'b1;
					s_d.rsp_err = 1'b1;
				end else begin
					s_d.req = REQ;
					s_d.idx = 3'h0;
					s_d.total = n_steps(REQ.op);
					s_d.rsp_err = 1'b0;
					if (REQ.op != OP_SECT_ADD && REQ.op != OP_SUSPEND) begin
						s_d.win = 16'h0;
					end
					s_d.st = (REQ.op == OP_READ) ? H_READ : H_WRITE;
				end
			end
			H_WRITE: begin
				s_d.st = H_WAIT;
				s_d.rd = 1'b0;
			end
			H_READ: begin
				s_d.st = H_WAIT;
				s_d.rd = 1'b1;
			end
			H_WAIT: if (bc_done) begin
				if (s_q.rd) begin
					s_d.rsp_data = bc_rdata;
					s_d.rsp_valid = 1'b1;
					s_d.st = H_IDLE;
				end else if ((s_q.idx + 3'h1) < s_q.total) begin
					s_d.idx = s_q.idx + 3'h1;
					s_d.st = H_WRITE;
				end else if (s_q.req.op == OP_ID) begin
					s_d.st = H_READ; // identifier read
				end else begin
					s_d.rsp_valid = 1'b1;
					s_d.st = H_IDLE;
					if (s_q.req.op == OP_SECT_ERASE ||
						s_q.req.op == OP_SECT_ADD) begin
						s_d.win = 16'(`WIN_LOAD);
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	flash_bus_cycle u_cycle (
		.clk(CLK),
		.rst(RST),
		.start(bc_start),
		.wr(bc_wr),
		.addr(cyc[26:8]),
		.wdata(cyc[7:0]),
		.dq_i(FLASH_DQ_I),
		.done(bc_done),
		.rdata(bc_rdata),
		.pins(FLASH)
	);

	assign RSP_VALID = s_q.rsp_valid;
	assign RSP_DATA = s_q.rsp_data;
	assign RSP_ERR = s_q.rsp_err;

	reset_write_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_RESET |-> ##3 !FLASH.we_n &&
			FLASH.dq_o == `CMD_RESET)
		else $error("reset request did not write F0");

	id_seq_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_ID |-> ##[8:20] !FLASH.we_n &&
			FLASH.dq_o == `CMD_ID && FLASH.addr == `ADDR_555)
		else $error("identifier command write missing");

	prog_seq_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_PROG |-> ##[8:20] !FLASH.we_n &&
			FLASH.dq_o == `CMD_PROG && FLASH.addr == `ADDR_555)
		else $error("program setup write missing");

	chip_seq_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_CHIP_ERASE |-> ##[20:40] !FLASH.we_n &&
			FLASH.dq_o == `CMD_CHIP && FLASH.addr == `ADDR_555)
		else $error("chip erase final write missing");

	win_refuse_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_SECT_ADD && s_q.win == 16'h0 |=>
			RSP_VALID && RSP_ERR && REQ_READY)
		else $error("late sector load not refused");

	read_start_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_READ |-> ##3 !FLASH.oe_n && FLASH.we_n)
		else $error("read strobe not issued");

	sect_add_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_SECT_ADD && s_q.win != 16'h0 |-> ##3
			!FLASH.we_n && FLASH.dq_o == `CMD_SECT &&
			FLASH.addr == $past(REQ.addr, 3))
		else $error("sector load write missing");

	sect_seq_a: assert property (@(posedge CLK) disable iff (RST)
		accept && REQ.op == OP_SECT_ERASE |-> ##28 !FLASH.we_n &&
			FLASH.dq_o == `CMD_SECT && FLASH.addr == $past(REQ.addr, 28))
		else $error("sector erase final write wrong");

endmodule // flash_host
`default_nettype wire

/* File: test/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'h3c // arbitrary value
) (
	input wire flash_host_pkg::pins_t pins,
	output logic [7:0] dq
);
	import flash_host_pkg::*;
	logic [7:0] mem [0:524287];
	logic [18:0] wa;
	logic [7:0] wd;
	logic [7:0] rd = 8'h00;
	int st = 0;
	bit id = 0;
	wire logic wr = !pins.we_n && !pins.ce_n;
	wire logic u5 = wa[10:0] == 11'h555;
	wire logic u2 = wa[10:0] == 11'h2aa;

	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
	end
	always @(posedge wr) wa = pins.addr;
	always @(negedge wr) begin
		wd = pins.dq_o;
		if (wd == 8'hf0 && st != 3) begin // data byte f0 still programs
			st = 0;
			id = 0;
		end else case (st)
			0, 4: st = (u5 && wd == 8'haa) ? st + 1 : 0;
			1, 5: st = (u2 && wd == 8'h55) ? st + 1 : 0;
			2: begin
				if (u5 && wd == 8'h90) id = 1;
				st = !u5 ? 0 : wd == 8'ha0 ? 3 : wd == 8'h80 ? 4 : 0;
			end
			3: begin
				mem[wa] = mem[wa] & wd; // program ends at once
				st = 0;
			end
			default: begin
				if (st == 6 && u5 && wd == 8'h10) begin
					foreach (mem[i]) mem[i] = 8'hff;
				end else if (wd == 8'h30) begin
					for (int i = 0; i < 65536; i++) mem[{wa[18:16], i[15:0]}] = 8'hff;
				end
				st = (wd == 8'h30) ? 7 : (u5 && wd == 8'haa) ? 1 : 0;
			end
		endcase
	end
	always @* begin
		if (!pins.ce_n && !pins.oe_n && pins.we_n) begin
			rd = id ? (pins.addr[0] ? PART_CODE : MAKER_CODE) : mem[pins.addr];
		end
		dq = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
	end
endmodule // flash_dev_model

`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import flash_host_pkg::*;
	localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
	localparam logic [7:0] PART = 8'h3c; // arbitrary value
	logic clk, rst, req_valid, req_ready, rsp_valid, rsp_err;
	logic [7:0] rsp_data, dq, got, d;
	logic [18:0] a, b;
	req_t req;
	pins_t pins;
	int num_errors = 0;
	int num_checks = 0;
	logic [7:0] exp_mem [int];

	flash_host dut (.CLK(clk), .RST(rst), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ(req), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .RSP_ERR(rsp_err), .FLASH_DQ_I(dq),
		.FLASH(pins));
	flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev (
		.pins(pins), .dq(dq));

	task automatic end_sim();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	function automatic logic [7:0] ref_rd(input int k);
		return exp_mem.exists(k) ? exp_mem[k] : 8'hff;
	endfunction
	task automatic op(input op_t o, input logic [18:0] ad,
		input logic [7:0] dd, input int lat);
		int n;
		n = 0;
		req_valid = 1;
		req = '{o, ad, dd};
		do @(posedge clk); while (req_ready !== 1'b1);
		#1 req_valid = 0;
		req = req_t'(31'($urandom));
		while (rsp_valid !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		if (lat >= 0) cmp("latency", lat, n);
		got = rsp_data;
		@(posedge clk);
		#1 cmp("pulse", 0, rsp_valid);
	endtask
	task automatic rd_chk(input logic [18:0] ad, input logic [7:0] e);
		op(OP_READ, ad, 8'h00, 8);
		cmp("read", e, got);
	endtask
	task automatic prog(input logic [18:0] ad, input logic [7:0] dd);
		op(OP_PROG, ad, dd, 20);
		exp_mem[ad] = ref_rd(ad) & dd;
	endtask
	task automatic sect_clr(input logic [2:0] s);
		foreach (exp_mem[k]) if (k[18:16] == s) exp_mem[k] = 8'hff;
	endtask

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 10000);
		num_errors++;
		end_sim();
	end
	always @(posedge clk) if (!rst) begin
		if (!pins.we_n) begin
			cmp("write ctl", 3'b101, {pins.oe_n, pins.ce_n, pins.dq_oe});
		end
		if (!pins.oe_n) begin
			cmp("read ctl", 3'b100, {pins.we_n, pins.ce_n, pins.dq_oe});
		end
	end

	initial begin
		void'($urandom(32'h9eeb));
		rst = 1;
		req_valid = 0;
		req = '0;
		repeat (4) @(posedge clk);
		#1 rst = 0;
		cmp("idle", 5'b10111, {req_ready, pins.dq_oe, pins.ce_n,
			pins.oe_n, pins.we_n});
		rd_chk(19'h12345, 8'hff);
		for (int i = 0; i < 6; i++) begin
			a = 19'($urandom);
			d = 8'($urandom);
			prog(a, d);
			rd_chk(a, ref_rd(a));
			rd_chk(a, ref_rd(a));
		end
		b = {16'($urandom), 3'b000};
		op(OP_ID, b, 8'h00, 23);
		cmp("maker", MAKER, got);
		rd_chk(b | 19'h1, PART);
		op(OP_RESET, 19'h0, 8'h00, 5);
		rd_chk(a, ref_rd(a));
		op(OP_SUSPEND, a, 8'h00, 5);
		op(OP_RESUME, a, 8'h00, 5);
		rd_chk(a, ref_rd(a));
		prog({3'd2, 16'h0100}, 8'h0f);
		prog({3'd5, 16'h0200}, 8'h3c);
		op(OP_SECT_ERASE, {3'd2, 16'h0}, 8'h00, 30);
		sect_clr(3'd2);
		op(OP_SECT_ADD, {3'd5, 16'h0}, 8'h00, 5);
		sect_clr(3'd5);
		cmp("err", 0, rsp_err);
		repeat (1300) @(posedge clk);
		#1 op(OP_SECT_ADD, {3'd6, 16'h0}, 8'h00, 0);
		cmp("err", 1, rsp_err);
		rd_chk({3'd2, 16'h0100}, 8'hff);
		rd_chk({3'd5, 16'h0200}, 8'hff);
		prog({3'd5, 16'h0200}, 8'h96);
		rd_chk({3'd5, 16'h0200}, ref_rd({3'd5, 16'h0200}));
		op(OP_CHIP_ERASE, 19'h0, 8'h00, 30);
		exp_mem.delete();
		cmp("err", 0, rsp_err);
		rd_chk(a, 8'hff);
		end_sim();
	end
endmodule // testbench

`default_nettype wire
